// [rtl/spi_regs.sv]
// Register side of a serial peripheral controller: interrupts, data words, clock, select
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "spi_regs_defs.svh"

// What this block does
// [RULE1] Reading the interrupt clear register returns zero and changes nothing.
// [RULE2] Writing one to bit 5 or 4 clears select-end or command-count interrupt.
// [RULE3] Writing one to bit 3 or 2 clears underrun or overflow interrupt.
// [RULE4] Writing one to bit 1 or 0 clears receive-ready or transmit-done flag.
// [RULE5] Receive word resets to zero; a read returns it and then empties it.
// [RULE6] Transmit word is write-only, resets to zero, each write replaces old data.
// [RULE7] Style 0: serial clock is bus clock over two to the power value+1, 0..15.
// [RULE8] Style 1: serial clock is bus clock over twice value+1, 0..255.
// [RULE9] Select bit one selects its target; bit 0 drives the pin; resets to zero.
// [RULE10] Select pin is active low, inverted to active high in framed mode.
// [RULE11] Masked status equals raw status ANDed with control mask bits for the low four flags, with enable bits for the upper two.
// [RULE12] Select-end interrupt rises when select goes to inactive level.
// [RULE13] Zero bits and reserved bits of a clear write change nothing.
// [RULE14] A set event in the same cycle as its clear keeps the flag set.
module spi_regs
    import spi_regs_pkg::*;
#(
    parameter int DIV_W = `DIVIDER_WIDTH
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_RX_VALID,
    input wire logic [31:0] I_RX_DATA,
    input wire logic I_TX_DONE_EVT,
    input wire logic I_TX_UNDERRUN_EVT,
    input wire logic I_COMMAND_COUNT_EVT,
    output logic [31:0] O_TX_DATA,
    output logic O_TX_LOAD,
    output logic O_SERIAL_CLOCK_OUT,
    output logic O_SELECT_PIN_ZERO,
    output logic O_IRQ
);

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic wr_en;
    wire logic rd_en;
    wire logic hit_ctrl;
    wire logic hit_raw;
    wire logic hit_mask;
    wire logic hit_ien;
    wire logic hit_clr;
    wire logic hit_rx;
    wire logic hit_tx;
    wire logic hit_div;
    wire logic hit_sel;
    wire logic hit_irq;
    wire logic hit_any;
    wire logic wr_ctrl;
    wire logic wr_ien;
    wire logic wr_clr;
    wire logic wr_tx;
    wire logic wr_div;
    wire logic wr_sel;

    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
    assign hit_ctrl = (I_PADDR == `OFS_CONTROL);
    assign hit_raw = (I_PADDR == `OFS_RAW_STATUS);
    assign hit_mask = (I_PADDR == `OFS_MASKED_STATUS);
    assign hit_ien = (I_PADDR == `OFS_INT_ENABLE);
    assign hit_clr = (I_PADDR == `OFS_INTERRUPT_CLEAR);
    assign hit_rx = (I_PADDR == `OFS_RECEIVE_WORD);
    assign hit_tx = (I_PADDR == `OFS_TRANSMIT_WORD);
    assign hit_div = (I_PADDR == `OFS_SERIAL_CLOCK_DIVIDER);
    assign hit_sel = (I_PADDR == `OFS_TARGET_SELECT);
    assign hit_irq = (I_PADDR == `OFS_IRQ_STATUS);
    assign hit_any = hit_ctrl | hit_raw | hit_mask | hit_ien | hit_clr | hit_rx | hit_tx
        | hit_div | hit_sel | hit_irq;

    // Write strobes, one per writable register
    assign wr_ctrl = wr_en && hit_ctrl;
    assign wr_ien = wr_en && hit_ien;
    assign wr_clr = wr_en && hit_clr;
    assign wr_tx = wr_en && hit_tx;
    assign wr_div = wr_en && hit_div;
    assign wr_sel = wr_en && hit_sel;

    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !hit_any;

    // ****************************************
    // Registers
    // ****************************************
    logic [`CTRL_WIDTH-1:0] ctrl_r;
    logic [`IRQ_COUNT-1:0] raw_r;
    logic [`IRQ_COUNT-1:0] raw_nxt;
    logic [`IRQ_COUNT-1:0] ien_r;
    word_t rx_word_r;
    word_t tx_word_r;
    logic tx_load_r;
    logic [DIV_W-1:0] div_r;
    logic [`SELECT_WIDTH-1:0] sel_r;
    logic sel_pin_r;
    logic sel_active_d_r;
    word_t prdata_r;

    wire logic div_style;
    wire logic frame_mode;
    wire logic [3:0] mask_bits;
    wire logic sel_active;
    wire logic sel_end_evt;
    wire logic rx_overflow_evt;
    wire logic rx_read;
    wire logic [`IRQ_COUNT-1:0] set_evt;
    wire logic [`IRQ_COUNT-1:0] clr_req;
    wire logic [`IRQ_COUNT-1:0] masked;

    assign div_style = ctrl_r[`CTRL_DIVIDER_STYLE];
    assign frame_mode = ctrl_r[`CTRL_FRAME_MODE];
    assign mask_bits = ctrl_r[`CTRL_MASK_LSB+3:`CTRL_MASK_LSB];

    // ****************************************
    // Interrupt flags
    // ****************************************
    assign sel_active = sel_r[0];
    assign sel_end_evt = sel_active_d_r && !sel_active; // [RULE12]
    assign rx_read = rd_en && hit_rx;
    assign rx_overflow_evt = I_RX_VALID && raw_r[`BIT_RX_READY] && !rx_read;

    assign set_evt[`BIT_TX_DONE] = I_TX_DONE_EVT;
    assign set_evt[`BIT_RX_READY] = I_RX_VALID;
    assign set_evt[`BIT_RX_OVERFLOW] = rx_overflow_evt;
    assign set_evt[`BIT_TX_UNDERRUN] = I_TX_UNDERRUN_EVT;
    assign set_evt[`BIT_COMMAND_COUNT] = I_COMMAND_COUNT_EVT;
    assign set_evt[`BIT_SELECT_END] = sel_end_evt;

    // Only the low six bits act; zero bits and reserved bits do nothing
    assign clr_req = wr_clr ? I_PWDATA[`IRQ_COUNT-1:0] : '0; // [RULE2] [RULE3] [RULE4] [RULE13]

    // ****************************************
    // Per-flag next value
    // ****************************************
    // Set beats clear; receive-ready also drops when its word is read
    for (genvar g = 0; g < `IRQ_COUNT; g++) begin : g_flag
        wire logic drop;

        if (g == `BIT_RX_READY) begin : g_rx
            assign drop = clr_req[g] || rx_read;
        end else begin : g_other
            assign drop = clr_req[g]; // [RULE2] [RULE3] [RULE4]
        end

        assign raw_nxt[g] = set_evt[g] ? 1'b1 // [RULE14]
            : drop ? 1'b0
            : raw_r[g];
    end

    // ****************************************
    // Interrupt output
    // ****************************************
    wire logic [`IRQ_COUNT-1:0] irq_gate;
    wire logic irq_nxt;

    // Low four flags need both mask and enable, upper two the enable
    assign irq_gate = {ien_r[5:4], mask_bits} & ien_r;
    assign irq_nxt = |(raw_nxt & irq_gate);

    // Low four flags gated by control mask, upper two by the enable register
    assign masked[3:0] = raw_r[3:0] & mask_bits; // [RULE11]
    assign masked[5:4] = raw_r[5:4] & ien_r[5:4];

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            raw_r <= '0;
            O_IRQ <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
            O_IRQ <= irq_nxt;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ctrl_r <= '0;
            ien_r <= '0;
            div_r <= '0;
            sel_r <= '0; // [RULE9]
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= I_PWDATA[`CTRL_WIDTH-1:0];
            end
            if (wr_ien) begin
                ien_r <= I_PWDATA[`IRQ_COUNT-1:0];
            end
            if (wr_div) begin
                div_r <= I_PWDATA[DIV_W-1:0];
            end
            if (wr_sel) begin
                sel_r <= I_PWDATA[`SELECT_WIDTH-1:0]; // [RULE9]
            end
        end
    end

    // ****************************************
    // Data words
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rx_word_r <= `RESET_WORD; // [RULE5]
            tx_word_r <= `RESET_WORD; // [RULE6]
            tx_load_r <= 1'b0;
        end else begin
            if (I_RX_VALID) begin
                rx_word_r <= I_RX_DATA;
            end else if (rx_read) begin
                rx_word_r <= `RESET_WORD; // [RULE5]
            end
            tx_load_r <= wr_tx;
            if (wr_tx) begin
                tx_word_r <= I_PWDATA; // [RULE6]
            end
        end
    end

    assign O_TX_DATA = tx_word_r;
    assign O_TX_LOAD = tx_load_r;

    // ****************************************
    // Serial clock divider
    // ****************************************
    logic [15:0] div_cnt_r;
    logic sclk_r;
    wire logic [15:0] half_period;
    wire logic [3:0] pow_sel;
    wire logic [15:0] pow_half;
    wire logic [15:0] lin_half;
    wire logic [15:0] cnt_inc;
    wire logic cnt_wrap;

    // Style 0 values above the top power are held at the top power
    assign pow_sel = (div_r > DIV_W'(`DIVIDER_POW_MAX)) ? 4'hF : div_r[3:0];
    assign pow_half = 16'h0001 << pow_sel; // [RULE7]
    assign lin_half = 16'(div_r) + 16'h0001; // [RULE8]

    // Half period in bus clocks: 2^value for style 0, value+1 for style 1
    assign half_period = (div_style == DIV_LINEAR[0]) ? lin_half : pow_half;
    assign cnt_inc = div_cnt_r + 16'h0001;
    assign cnt_wrap = (cnt_inc >= half_period);

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            div_cnt_r <= '0;
            sclk_r <= 1'b0;
        end else if (cnt_wrap) begin
            div_cnt_r <= '0;
            sclk_r <= !sclk_r; // [RULE7] [RULE8]
        end else begin
            div_cnt_r <= cnt_inc;
        end
    end

    assign O_SERIAL_CLOCK_OUT = sclk_r;

    // ****************************************
    // Select pin
    // ****************************************
    wire logic sel_pin_nxt;

    // Active low, active high in framed mode
    assign sel_pin_nxt = frame_mode ? sel_active : !sel_active; // [RULE10]

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            sel_pin_r <= 1'b1;
            sel_active_d_r <= 1'b0;
        end else begin
            sel_pin_r <= sel_pin_nxt; // [RULE10]
            sel_active_d_r <= sel_active;
        end
    end

    assign O_SELECT_PIN_ZERO = sel_pin_r;

    // ****************************************
    // Read data
    // ****************************************
    wire word_t rd_ctrl;
    wire word_t rd_raw;
    wire word_t rd_mask;
    wire word_t rd_ien;
    wire word_t rd_div;
    wire word_t rd_sel;
    wire word_t rd_irq;
    wire word_t rd_mux;
    wire logic rd_setup;

    // Each readable register widened to one bus word
    assign rd_ctrl = 32'(ctrl_r);
    assign rd_raw = 32'(raw_r);
    assign rd_mask = 32'(masked);
    assign rd_ien = 32'(ien_r);
    assign rd_div = 32'(div_r);
    assign rd_sel = 32'(sel_r);
    assign rd_irq = {31'h0000_0000, O_IRQ};

    // Clear register and unmapped addresses read as zero
    assign rd_mux = hit_ctrl ? rd_ctrl
        : hit_raw ? rd_raw
        : hit_mask ? rd_mask
        : hit_ien ? rd_ien
        : hit_rx ? rx_word_r
        : hit_div ? rd_div
        : hit_sel ? rd_sel
        : hit_irq ? rd_irq
        : 32'h0000_0000; // [RULE1]

    // Captured in the setup cycle so it stands through the access phase
    assign rd_setup = I_PSEL && !I_PENABLE;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= rd_mux;
        end
    end

    assign O_PRDATA = prdata_r;

endmodule // spi_regs

// [rtl/spi_regs_defs.svh]
// Register offsets, field positions, reset values and counts of the serial register block
`ifndef SPI_REGS_DEFS_SVH
`define SPI_REGS_DEFS_SVH

`define OFS_CONTROL 12'h000
`define OFS_RAW_STATUS 12'h004
`define OFS_MASKED_STATUS 12'h008
`define OFS_INT_ENABLE 12'h00C
`define OFS_INTERRUPT_CLEAR 12'h010
`define OFS_RECEIVE_WORD 12'h014
`define OFS_TRANSMIT_WORD 12'h018
`define OFS_SERIAL_CLOCK_DIVIDER 12'h01C
`define OFS_TARGET_SELECT 12'h020
`define OFS_IRQ_STATUS 12'h024

`define BIT_TX_DONE 0
`define BIT_RX_READY 1
`define BIT_RX_OVERFLOW 2
`define BIT_TX_UNDERRUN 3
`define BIT_COMMAND_COUNT 4
`define BIT_SELECT_END 5
`define IRQ_COUNT 6

`define CTRL_MASK_LSB 4
`define CTRL_DIVIDER_STYLE 8
`define CTRL_FRAME_MODE 9
`define CTRL_WIDTH 10

`define DIVIDER_WIDTH 8
`define DIVIDER_POW_MAX 8'h0F
`define SELECT_WIDTH 1
`define RESET_WORD 32'h0000_0000

`endif

// [rtl/spi_regs_pkg.sv]
// Types shared by the serial register block
package spi_regs_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        DIV_POWER = 2'b00,
        DIV_LINEAR = 2'b01
    } div_style_e;
endpackage

// [tb/spi_regs_properties.sv]
// Concurrent checks on the ports of the serial register block
`timescale 1ns/1ps
`include "spi_regs_defs.svh"
module spi_regs_properties (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic I_RX_VALID,
    input wire logic [31:0] I_RX_DATA,
    input wire logic I_TX_DONE_EVT,
    input wire logic I_TX_UNDERRUN_EVT,
    input wire logic I_COMMAND_COUNT_EVT,
    input wire logic [31:0] O_TX_DATA,
    input wire logic O_TX_LOAD,
    input wire logic O_SELECT_PIN_ZERO,
    input wire logic O_IRQ
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    wire logic rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
    wire logic acc = I_PSEL && I_PENABLE;
    wire logic tx_wr = acc && I_PWRITE && I_PADDR == `OFS_TRANSMIT_WORD;
    wire logic evt = I_RX_VALID || I_TX_DONE_EVT || I_TX_UNDERRUN_EVT || I_COMMAND_COUNT_EVT;
    property p_clr_rd;
        rd_setup && I_PADDR == `OFS_INTERRUPT_CLEAR |=> O_PRDATA == 32'h0;
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register read not zero");
    property p_rx_rd;
        I_RX_VALID ##1 (rd_setup && !I_RX_VALID && I_PADDR == `OFS_RECEIVE_WORD)
            |=> O_PRDATA == $past(I_RX_DATA, 2);
    endproperty
    a_rx_rd: assert property (p_rx_rd) else $error("received word not returned");
    property p_tx_load;
        tx_wr |=> O_TX_LOAD && O_TX_DATA == $past(I_PWDATA);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit word not loaded");
    property p_load_only;
        O_TX_LOAD |-> $past(tx_wr);
    endproperty
    a_load_only: assert property (p_load_only) else $error("load without write");
    property p_tx_hold;
        !$past(tx_wr) |-> $stable(O_TX_DATA);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit word changed");
    property p_pin_cause;
        $changed(O_SELECT_PIN_ZERO) |-> $past(acc && I_PWRITE, 2);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("select pin moved alone");
    property p_irq_rise;
        $rose(O_IRQ) |-> $past(evt) || $past(evt, 2) || $past(evt, 3)
            || $past(acc) || $past(acc, 2) || $past(acc, 3);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose alone");
    property p_irq_fall;
        $fell(O_IRQ) |-> $past(acc) || $past(acc, 2) || $past(acc, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
    property p_ready;
        acc |-> O_PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready low in access");
    c_rx: cover property (p_rx_rd);
    c_irq: cover property ($rose(O_IRQ));
    c_load: cover property (tx_wr ##1 O_TX_LOAD);
endmodule // spi_regs_properties

bind spi_regs spi_regs_properties u_props (.*);

// [tb/spi_far_model.sv]
// Far side of the serial link: received words and link events
`timescale 1ns/1ps
module spi_far_model (
    input wire logic i_clk,
    input wire logic [31:0] i_tx_data,
    input wire logic i_tx_load,
    output logic o_rx_valid = 1'b0,
    output logic [31:0] o_rx_data = 32'h0,
    output logic [2:0] o_evt = 3'h0,
    output logic [31:0] o_last_tx = 32'h0
);
    // ****
    // Model
    // ****
    always @(posedge i_clk) begin
        if (o_rx_valid) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= ~o_rx_data;
        end
        if (|o_evt) begin
            o_evt <= 3'h0;
        end
        if (i_tx_load) begin
            o_last_tx <= i_tx_data;
        end
    end
    task automatic send_word(input logic [31:0] w);
        o_rx_valid <= 1'b1;
        o_rx_data <= w;
    endtask
    task automatic pulse(input int b);
        o_evt[b] <= 1'b1;
    endtask
endmodule // spi_far_model

// [tb/tb_top.sv]
// Self-checking bench of the serial register block
`timescale 1ns/1ps
`include "spi_regs_defs.svh"
module tb_top;
    import spi_regs_pkg::*;
    logic I_CLK = 1'b0;
    logic I_SRST;
    logic I_PSEL, I_PENABLE, I_PWRITE;
    logic [11:0] I_PADDR;
    word_t I_PWDATA;
    word_t O_PRDATA, O_TX_DATA, last_tx, rd;
    logic O_PREADY, O_PSLVERR, O_TX_LOAD, O_SERIAL_CLOCK_OUT, O_SELECT_PIN_ZERO, O_IRQ, perr;
    wire I_RX_VALID, I_TX_DONE_EVT, I_TX_UNDERRUN_EVT, I_COMMAND_COUNT_EVT;
    wire [31:0] I_RX_DATA;
    int num_errors = 0;
    int tests_run = 0;
    always #5 I_CLK = ~I_CLK;
    spi_regs DUT (.*);
    spi_far_model u_far (.i_clk(I_CLK), .i_tx_data(O_TX_DATA), .i_tx_load(O_TX_LOAD),
        .o_rx_valid(I_RX_VALID), .o_rx_data(I_RX_DATA), .o_last_tx(last_tx),
        .o_evt({I_COMMAND_COUNT_EVT, I_TX_UNDERRUN_EVT, I_TX_DONE_EVT}));
    // ****
    // Bus and compare
    // ****
    task automatic chk(input word_t got, input word_t exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input word_t d);
        int n = 0;
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_PREADY !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = O_PRDATA;
        perr = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input word_t d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input word_t e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_clk(input word_t ctl, input word_t div, input int per);
        int n = 0;
        wr(`OFS_CONTROL, ctl);
        wr(`OFS_SERIAL_CLOCK_DIVIDER, div);
        rdchk(`OFS_SERIAL_CLOCK_DIVIDER, div);
        repeat (2 * per) @(posedge I_CLK);
        while (O_SERIAL_CLOCK_OUT !== 1'b0) @(posedge I_CLK);
        while (O_SERIAL_CLOCK_OUT !== 1'b1) @(posedge I_CLK);
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_SERIAL_CLOCK_OUT === 1'b1);
        while (O_SERIAL_CLOCK_OUT === 1'b0) begin
            @(posedge I_CLK);
            n++;
        end
        chk(word_t'(n), word_t'(per));
    endtask
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_irq();
        int bits[4] = '{0, 3, 4, 5};
        word_t e = 32'h39;
        wr(`OFS_INT_ENABLE, 32'h3F);
        u_far.pulse(0);
        repeat (4) @(posedge I_CLK);
        chk({31'h0, O_IRQ}, 32'h0);
        wr(`OFS_CONTROL, 32'h0F0);
        repeat (3) @(posedge I_CLK);
        chk({31'h0, O_IRQ}, 32'h1);
        rdchk(`OFS_MASKED_STATUS, 32'h1);
        u_far.pulse(1);
        repeat (2) @(posedge I_CLK);
        u_far.pulse(2);
        wr(`OFS_TARGET_SELECT, 32'h1);
        wr(`OFS_TARGET_SELECT, 32'h0);
        rdchk(`OFS_RAW_STATUS, 32'h39);
        foreach (bits[i]) begin
            e &= ~(32'h1 << bits[i]);
            wr(`OFS_INTERRUPT_CLEAR, 32'h1 << bits[i]);
            rdchk(`OFS_RAW_STATUS, e);
        end
        repeat (3) @(posedge I_CLK);
        chk({31'h0, O_IRQ}, 32'h0);
    endtask
    initial begin
        I_SRST <= 1'b1;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
        I_PWRITE <= 1'b0;
        I_PADDR <= 12'h000;
        I_PWDATA <= 32'h0000_0000;
        repeat (16) @(posedge I_CLK);
        I_SRST <= 1'b0;
        chk(O_TX_DATA, 32'h0);
        chk({31'h0, O_SELECT_PIN_ZERO}, 32'h1);
        rdchk(`OFS_RECEIVE_WORD, 32'h0);
        rdchk(`OFS_TARGET_SELECT, 32'h0);
        rdchk(12'hFFC, 32'h0);
        chk({31'h0, perr}, 32'h1);
        u_far.send_word(32'hA5C3_0F01);
        rdchk(`OFS_RAW_STATUS, 32'h2);
        u_far.send_word(32'h1234_5678);
        rdchk(`OFS_RECEIVE_WORD, 32'h1234_5678);
        rdchk(`OFS_RECEIVE_WORD, 32'h0);
        wr(`OFS_INTERRUPT_CLEAR, 32'hFFFF_FFC0);
        rdchk(`OFS_RAW_STATUS, 32'h4);
        wr(`OFS_INTERRUPT_CLEAR, 32'h4);
        rdchk(`OFS_RAW_STATUS, 32'h0);
        rdchk(`OFS_INTERRUPT_CLEAR, 32'h0);
        t_irq();
        fork
            wr(`OFS_INTERRUPT_CLEAR, 32'h1);
            begin
                repeat (2) @(posedge I_CLK);
                u_far.pulse(0);
            end
        join
        rdchk(`OFS_RAW_STATUS, 32'h1);
        wr(`OFS_TRANSMIT_WORD, 32'h1234_5678);
        wr(`OFS_TRANSMIT_WORD, 32'hDEAD_BEEF);
        repeat (2) @(posedge I_CLK);
        chk(last_tx, 32'hDEAD_BEEF);
        wr(`OFS_TARGET_SELECT, 32'h1);
        repeat (2) @(posedge I_CLK);
        chk({31'h0, O_SELECT_PIN_ZERO}, 32'h0);
        wr(`OFS_CONTROL, 32'h200);
        repeat (2) @(posedge I_CLK);
        chk({31'h0, O_SELECT_PIN_ZERO}, 32'h1);
        t_clk(32'h0, 32'h2, 8);
        t_clk(32'h0, 32'h0, 2);
        t_clk(32'h100, 32'h5, 12);
        t_clk(32'h100, 32'hFF, 512);
        final_report();
    end
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
endmodule // tb_top
